// ==== pgc_codec.sv ====
// four-level gray/precode lane codec: transmit mapper, receive demapper, test patterns
//
// Overview of operation
// - incoming bits paired, first bit is high
// - pairs gray coded 00,01,11,10 to 0..3
// - symbols 0..3 map to levels -1..+1
// - gray coding precedes level encoding on transmit
// - optional precoder y = (x - y_prev) mod 4
// - receive decodes levels then inverse gray maps
// - receive decoder x = (y + y_prev) mod 4
// - receive decoder can be bypassed
// - short pattern: 13-bit sequence, 8191 symbols
// - short generator polynomial 1+x+x^2+x^12+x^13
// - simultaneous generators misaligned by distinct seeds
// - long pattern: 31-bit sequence, same mapping
`include "pgc_params.svh"

module pgc_codec
#(
    parameter logic [12:0] SHORT_SEED = `PGC_SHORT_SEED,
    parameter logic [30:0] LONG_SEED = `PGC_LONG_SEED
)
(
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire pgc_pkg::pgc_mode_type TX_MODE,
    input wire logic TX_PRECODE_EN,
    input wire logic TX_BIT,
    input wire logic TX_BIT_VALID,
    input wire logic RX_DECODE_EN,
    input wire pgc_pkg::pgc_level_type RX_LEVEL,
    input wire logic RX_LEVEL_VALID,
    output pgc_pkg::pgc_level_type TX_LEVEL,
    output logic TX_LEVEL_VALID,
    output logic TX_PAT_WRAP,
    output logic RX_BIT_A,
    output logic RX_BIT_B,
    output logic RX_PAIR_VALID
);
    import pgc_pkg::*;

    pgc_pat_if pat ();

    pgc_prbs
    #(
        .SHORT_SEED(SHORT_SEED),
        .LONG_SEED(LONG_SEED)
    )
    u_prbs
    (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .pat(pat)
    );

    // true for the data mode and for the unused code, which behaves as data
    function automatic logic mode_is_data(input pgc_mode_type mode);
        logic is_data;
        is_data = (mode != PGC_MODE_SHORT) && (mode != PGC_MODE_LONG);
        return is_data;
    endfunction : mode_is_data

    // y = (x - y_prev) mod 4; the two-bit width does the modulo
    function automatic logic [1:0] precode_sym(input logic [1:0] x, input logic [1:0] y_prev);
        logic [1:0] y;
        y = x - y_prev;
        return y;
    endfunction : precode_sym

    // x = (y + y_prev) mod 4
    function automatic logic [1:0] decode_sym(input logic [1:0] y, input logic [1:0] y_prev);
        logic [1:0] x;
        x = y + y_prev;
        return x;
    endfunction : decode_sym

    // bit pairing state
    pgc_pair_type pair_state;
    pgc_pair_type next_pair_state;
    logic first_bit;
    logic next_first_bit;
    pgc_mode_type last_mode;
    pgc_mode_type next_last_mode;
    logic [1:0] data_pair;
    logic data_fire;

    // pattern period state
    logic [12:0] short_cnt;
    logic [12:0] next_short_cnt;
    logic next_tx_pat_wrap;

    // symbol output state
    logic [1:0] prec_state;
    logic [1:0] next_prec_state;
    pgc_level_type next_tx_level;
    logic next_tx_level_valid;
    logic [1:0] tx_pair;
    logic tx_fire;
    logic [1:0] gray_sym;
    logic [1:0] out_sym;

    // receive state
    logic [1:0] dec_state;
    logic [1:0] next_dec_state;
    logic next_rx_bit_a;
    logic next_rx_bit_b;
    logic next_rx_pair_valid;
    logic [1:0] rx_sym;
    logic [1:0] rx_data_sym;
    logic [1:0] rx_ab;

    always_comb
    begin
        next_pair_state = pair_state;
        next_first_bit = first_bit;
        next_last_mode = TX_MODE;
        data_pair = 2'h0;
        data_fire = 1'b0;
        if (!mode_is_data(TX_MODE))
        begin
            // bits offered during a pattern run are ignored
            next_pair_state = PGC_PAIR_EMPTY;
        end
        else
        begin
            // a half pair left over from a pattern run is dropped
            if (!mode_is_data(last_mode))
            begin
                next_pair_state = PGC_PAIR_EMPTY;
            end
            if (TX_BIT_VALID)
            begin
                if (next_pair_state == PGC_PAIR_EMPTY)
                begin
                    next_first_bit = TX_BIT;
                    next_pair_state = PGC_PAIR_HALF;
                end
                else
                begin
                    data_pair = {first_bit, TX_BIT};
                    data_fire = 1'b1;
                    next_pair_state = PGC_PAIR_EMPTY;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            pair_state <= PGC_PAIR_EMPTY;
            first_bit <= 1'b0;
            last_mode <= PGC_MODE_DATA;
        end
        else
        begin
            pair_state <= next_pair_state;
            first_bit <= next_first_bit;
            last_mode <= next_last_mode;
        end
    end

    always_comb
    begin
        next_short_cnt = short_cnt;
        next_tx_pat_wrap = 1'b0;
        pat.advance_short = (TX_MODE == PGC_MODE_SHORT);
        pat.advance_long = (TX_MODE == PGC_MODE_LONG);
        if (TX_MODE == PGC_MODE_SHORT)
        begin
            // the count restarts whenever the short pattern is entered
            if (short_cnt == (`PGC_SHORT_PERIOD - 13'h0001) || last_mode != TX_MODE)
            begin
                next_short_cnt = `PGC_CNT_RST;
            end
            else
            begin
                next_short_cnt = short_cnt + 13'h0001;
            end
            next_tx_pat_wrap = (next_short_cnt == `PGC_CNT_RST);
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            short_cnt <= `PGC_CNT_RST;
            TX_PAT_WRAP <= 1'b0;
        end
        else
        begin
            short_cnt <= next_short_cnt;
            TX_PAT_WRAP <= next_tx_pat_wrap;
        end
    end

    always_comb
    begin
        next_prec_state = prec_state;
        next_tx_level = TX_LEVEL;
        next_tx_level_valid = 1'b0;
        unique case (TX_MODE)
            PGC_MODE_SHORT:
            begin
                // one pattern symbol every clock
                tx_pair = pat.short_pair;
                tx_fire = 1'b1;
            end
            PGC_MODE_LONG:
            begin
                tx_pair = pat.long_pair;
                tx_fire = 1'b1;
            end
            default:
            begin
                tx_pair = data_pair;
                tx_fire = data_fire;
            end
        endcase
        gray_sym = pgc_gray(tx_pair);
        if (TX_PRECODE_EN)
        begin
            out_sym = precode_sym(gray_sym, prec_state);
        end
        else
        begin
            out_sym = gray_sym;
        end
        if (tx_fire)
        begin
            // the delay follows every emitted symbol, so enabling later starts clean
            next_prec_state = out_sym;
            next_tx_level = pgc_to_level(out_sym);
            next_tx_level_valid = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            prec_state <= `PGC_SYM_RST;
            TX_LEVEL <= PGC_LVL_M1;
            TX_LEVEL_VALID <= 1'b0;
        end
        else
        begin
            prec_state <= next_prec_state;
            TX_LEVEL <= next_tx_level;
            TX_LEVEL_VALID <= next_tx_level_valid;
        end
    end

    always_comb
    begin
        next_dec_state = dec_state;
        next_rx_bit_a = RX_BIT_A;
        next_rx_bit_b = RX_BIT_B;
        next_rx_pair_valid = 1'b0;
        rx_sym = RX_LEVEL;
        if (RX_DECODE_EN)
        begin
            rx_data_sym = decode_sym(rx_sym, dec_state);
        end
        else
        begin
            rx_data_sym = rx_sym;
        end
        rx_ab = pgc_ungray(rx_data_sym);
        if (RX_LEVEL_VALID)
        begin
            // delay tracks the line even while bypassed, so enabling is clean
            next_dec_state = rx_sym;
            next_rx_bit_a = rx_ab[1];
            next_rx_bit_b = rx_ab[0];
            next_rx_pair_valid = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            dec_state <= `PGC_SYM_RST;
            RX_BIT_A <= 1'b0;
            RX_BIT_B <= 1'b0;
            RX_PAIR_VALID <= 1'b0;
        end
        else
        begin
            dec_state <= next_dec_state;
            RX_BIT_A <= next_rx_bit_a;
            RX_BIT_B <= next_rx_bit_b;
            RX_PAIR_VALID <= next_rx_pair_valid;
        end
    end
endmodule : pgc_codec

// ==== pgc_params.svh ====
// constants for the four-level gray/precode lane codec
`ifndef PGC_PARAMS_SVH
`define PGC_PARAMS_SVH

`define PGC_SHORT_LEN 13
`define PGC_LONG_LEN 31
`define PGC_SHORT_PERIOD 13'h1FFF
`define PGC_SHORT_SEED 13'h0001
`define PGC_LONG_SEED 31'h00000001
`define PGC_SYM_RST 2'h0
`define PGC_CNT_RST 13'h0000

`endif

// ==== pgc_pkg.sv ====
// types and mapping functions for the four-level gray/precode lane codec
package pgc_pkg;

    typedef enum logic [1:0]
    {
        PGC_MODE_DATA = 2'b00,
        PGC_MODE_SHORT = 2'b01,
        PGC_MODE_LONG = 2'b10
    } pgc_mode_type;

    // level code: 00 is -1, 01 is -1/3, 10 is +1/3, 11 is +1
    typedef enum logic [1:0]
    {
        PGC_LVL_M1 = 2'b00,
        PGC_LVL_M13 = 2'b01,
        PGC_LVL_P13 = 2'b10,
        PGC_LVL_P1 = 2'b11
    } pgc_level_type;

    typedef enum logic
    {
        PGC_PAIR_EMPTY = 1'b0,
        PGC_PAIR_HALF = 1'b1
    } pgc_pair_type;

    function automatic logic [1:0] pgc_gray(input logic [1:0] ab);
        logic [1:0] sym;
        sym = {ab[1], ab[1] ^ ab[0]};
        return sym;
    endfunction : pgc_gray

    function automatic logic [1:0] pgc_ungray(input logic [1:0] sym);
        logic [1:0] ab;
        ab = {sym[1], sym[1] ^ sym[0]};
        return ab;
    endfunction : pgc_ungray

    function automatic pgc_level_type pgc_to_level(input logic [1:0] sym);
        pgc_level_type lvl;
        lvl = pgc_level_type'(sym);
        return lvl;
    endfunction : pgc_to_level

endpackage : pgc_pkg

// ==== pgc_pat_if.sv ====
// carrier between the lane codec and its test pattern generators
interface pgc_pat_if;
    logic advance_short;
    logic advance_long;
    logic [1:0] short_pair;
    logic [1:0] long_pair;

    modport gen
    (
        input advance_short,
        input advance_long,
        output short_pair,
        output long_pair
    );

    modport user
    (
        output advance_short,
        output advance_long,
        input short_pair,
        input long_pair
    );
endinterface : pgc_pat_if

// ==== pgc_prbs.sv ====
// pseudo-random bit pair generators for the short and long test patterns
`include "pgc_params.svh"

module pgc_prbs
#(
    parameter logic [12:0] SHORT_SEED = `PGC_SHORT_SEED,
    parameter logic [30:0] LONG_SEED = `PGC_LONG_SEED
)
(
    input wire logic clk,
    input wire logic rst_b,
    pgc_pat_if.gen pat
);
    import pgc_pkg::*;

    logic [12:0] short_state;
    logic [12:0] next_short_state;
    logic [30:0] long_state;
    logic [30:0] next_long_state;
    logic [12:0] s_mid;
    logic [30:0] l_mid;
    logic [12:0] s_two;
    logic [30:0] l_two;

    // one shift of 1 + x + x^2 + x^12 + x^13
    function automatic logic [12:0] short_step(input logic [12:0] s);
        return {s[11:0], s[12] ^ s[11] ^ s[1] ^ s[0]};
    endfunction : short_step

    // one shift of 1 + x^28 + x^31
    function automatic logic [30:0] long_step(input logic [30:0] s);
        return {s[29:0], s[30] ^ s[27]};
    endfunction : long_step

    always_comb
    begin
        s_mid = short_step(short_state);
        l_mid = long_step(long_state);
        s_two = short_step(s_mid);
        l_two = long_step(l_mid);
        next_short_state = short_state;
        next_long_state = long_state;
        // first generated bit becomes the high bit of the pair
        pat.short_pair = {s_mid[0], s_two[0]};
        pat.long_pair = {l_mid[0], l_two[0]};
        if (pat.advance_short)
        begin
            next_short_state = s_two;
        end
        if (pat.advance_long)
        begin
            next_long_state = l_two;
        end
        // a zero state would lock up; force a legal one
        if (next_short_state == 13'h0000)
        begin
            next_short_state = 13'h0001;
        end
        if (next_long_state == 31'h00000000)
        begin
            next_long_state = 31'h00000001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            // per-lane seeds keep simultaneous generators misaligned
            short_state <= (SHORT_SEED == 13'h0000) ? 13'h0001 : SHORT_SEED;
            long_state <= (LONG_SEED == 31'h00000000) ? 31'h00000001 : LONG_SEED;
        end
        else
        begin
            short_state <= next_short_state;
            long_state <= next_long_state;
        end
    end
endmodule : pgc_prbs

// ==== pgc_codec_checker.sv ====
// port checks for the four-level lane codec
module pgc_codec_checker
import pgc_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire pgc_mode_type TX_MODE,
    input wire logic TX_PRECODE_EN,
    input wire logic TX_BIT,
    input wire logic TX_BIT_VALID,
    input wire logic RX_DECODE_EN,
    input wire pgc_level_type RX_LEVEL,
    input wire logic RX_LEVEL_VALID,
    input wire pgc_level_type TX_LEVEL,
    input wire logic TX_LEVEL_VALID,
    input wire logic TX_PAT_WRAP,
    input wire logic RX_BIT_A,
    input wire logic RX_BIT_B,
    input wire logic RX_PAIR_VALID
);
    timeunit 1ns;
    timeprecision 100ps;
    logic half;
    logic a_bit;
    logic data_m;
    logic [1:0] prev_tx;
    logic [1:0] prev_rx;
    logic [1:0] gx;
    logic [1:0] exp_tx;
    logic [1:0] dx;
    logic [1:0] exp_rx;
    always_comb
    begin
        data_m = TX_MODE != PGC_MODE_SHORT && TX_MODE != PGC_MODE_LONG;
        gx = {a_bit, a_bit ^ TX_BIT};
        exp_tx = 2'(gx - (TX_PRECODE_EN ? prev_tx : 2'h0));
        dx = 2'(RX_LEVEL + (RX_DECODE_EN ? prev_rx : 2'h0));
        exp_rx = {dx[1], dx[1] ^ dx[0]};
    end
    // mirrors pairing and the one-symbol delay states
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            half <= 1'b0;
            a_bit <= 1'b0;
            prev_tx <= 2'h0;
            prev_rx <= 2'h0;
        end
        else
        begin
            if (!data_m)
                half <= 1'b0;
            else if (TX_BIT_VALID)
            begin
                half <= ~half;
                a_bit <= TX_BIT;
            end
            if (TX_LEVEL_VALID)
                prev_tx <= TX_LEVEL;
            if (RX_LEVEL_VALID)
                prev_rx <= RX_LEVEL;
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    sequence b_taken;
        data_m && TX_BIT_VALID && half;
    endsequence
    sequence short_entry;
        TX_MODE == PGC_MODE_SHORT && $past(TX_MODE) != PGC_MODE_SHORT;
    endsequence
    tx_pair_a: assert property
        (b_taken |=> TX_LEVEL_VALID && TX_LEVEL == $past(exp_tx)) else $error("bad pair level");
    tx_idle_a: assert property
        (data_m && !(TX_BIT_VALID && half) |=> !TX_LEVEL_VALID) else $error("stray symbol");
    tx_hold_a: assert property
        (!TX_LEVEL_VALID |-> $stable(TX_LEVEL)) else $error("level moved while idle");
    pat_stream_a: assert property
        (!data_m |=> TX_LEVEL_VALID) else $error("pattern symbol missing");
    wrap_entry_a: assert property
        (short_entry |=> TX_PAT_WRAP) else $error("no wrap on pattern entry");
    wrap_valid_a: assert property
        (TX_PAT_WRAP |-> TX_LEVEL_VALID && $past(TX_MODE) == PGC_MODE_SHORT) else $error("bad wrap");
    rx_pair_a: assert property
        (RX_LEVEL_VALID |=> RX_PAIR_VALID && {RX_BIT_A, RX_BIT_B} == $past(exp_rx))
        else $error("bad received pair");
    rx_quiet_a: assert property
        (!RX_LEVEL_VALID |=> !RX_PAIR_VALID) else $error("stray received pair");
endmodule : pgc_codec_checker

bind pgc_codec pgc_codec_checker chk
(
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .TX_MODE(TX_MODE), .TX_PRECODE_EN(TX_PRECODE_EN),
    .TX_BIT(TX_BIT), .TX_BIT_VALID(TX_BIT_VALID), .RX_DECODE_EN(RX_DECODE_EN),
    .RX_LEVEL(RX_LEVEL), .RX_LEVEL_VALID(RX_LEVEL_VALID), .TX_LEVEL(TX_LEVEL),
    .TX_LEVEL_VALID(TX_LEVEL_VALID), .TX_PAT_WRAP(TX_PAT_WRAP), .RX_BIT_A(RX_BIT_A),
    .RX_BIT_B(RX_BIT_B), .RX_PAIR_VALID(RX_PAIR_VALID)
);

// ==== pgc_channel.sv ====
// loopback channel from the transmit driver to the receiver
module pgc_channel
import pgc_pkg::*;
(
    input wire logic clk,
    input wire pgc_level_type tx_level,
    input wire logic tx_valid,
    output pgc_level_type rx_level,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        rx_level = PGC_LVL_M1;
        rx_valid = 1'b0;
    end
    // between symbols the line flips to the inverse of its own previous level on every clock
    always @(posedge clk)
    begin
        rx_valid <= tx_valid;
        rx_level <= tx_valid ? tx_level : pgc_level_type'(~rx_level);
    end
endmodule : pgc_channel

// ==== tb_top.sv ====
// self-checking bench for the four-level lane codec
`include "pgc_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pgc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    pgc_mode_type tx_mode = PGC_MODE_DATA;
    logic pre_en = 1'b0;
    logic tx_bit = 1'b0;
    logic tx_bv = 1'b0;
    logic dec_en = 1'b0;
    pgc_level_type rx_level;
    pgc_level_type tx_level;
    logic rx_lv, tx_lv, wrap, bit_a, bit_b, pv;
    int error_cnt = 0;
    int total_checks = 0;
    logic [1:0] yprev;
    logic [12:0] s13;
    logic [30:0] s31;
    // symbol for pair index 00,01,10,11
    logic [7:0] gt = 8'hB4;
    pgc_codec DUT (.CORE_CLK(core_clk), .RST_B(rst_b), .TX_MODE(tx_mode),
        .TX_PRECODE_EN(pre_en), .TX_BIT(tx_bit), .TX_BIT_VALID(tx_bv), .RX_DECODE_EN(dec_en),
        .RX_LEVEL(rx_level), .RX_LEVEL_VALID(rx_lv), .TX_LEVEL(tx_level),
        .TX_LEVEL_VALID(tx_lv), .TX_PAT_WRAP(wrap), .RX_BIT_A(bit_a), .RX_BIT_B(bit_b),
        .RX_PAIR_VALID(pv));
    pgc_channel chan (.clk(core_clk), .tx_level(tx_level), .tx_valid(tx_lv),
        .rx_level(rx_level), .rx_valid(rx_lv));
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic do_reset;
        @(posedge core_clk);
        #1 rst_b = 1'b0;
        tx_mode = PGC_MODE_DATA;
        repeat (4) @(posedge core_clk);
        #1 rst_b = 1'b1;
        chk({tx_lv, pv, tx_level}, 4'h0);
        yprev = 2'h0;
        s13 = `PGC_SHORT_SEED;
        s31 = `PGC_LONG_SEED;
    endtask : do_reset
    function automatic logic nbit(input logic lng);
        logic f;
        f = lng ? s31[30] ^ s31[27] : s13[12] ^ s13[11] ^ s13[1] ^ s13[0];
        if (lng)
            s31 = {s31[29:0], f};
        else
            s13 = {s13[11:0], f};
        return f;
    endfunction : nbit
    task automatic tx_pair(input logic a, input logic b);
        logic [1:0] g;
        g = gt[{a, b} * 2 +: 2];
        if (pre_en)
            g = g - yprev;
        @(posedge core_clk);
        #1 tx_bit = a;
        tx_bv = 1'b1;
        @(posedge core_clk);
        #1 tx_bit = b;
        @(posedge core_clk);
        #1 tx_bv = 1'b0;
        chk({tx_lv, 1'b0, tx_level}, {2'b10, g});
        yprev = g;
        repeat (2) @(posedge core_clk);
        #1 chk({pv, 1'b0, bit_a, bit_b}, {2'b10, a, b});
    endtask : tx_pair
    task automatic t_data;
        do_reset();
        for (int i = 0; i < 8; i++)
        begin
            tx_mode = i[2] ? pgc_mode_type'(2'h3) : PGC_MODE_DATA;
            tx_pair(i[1], i[0]);
        end
        $display("data test done");
    endtask : t_data
    task automatic t_pre;
        do_reset();
        pre_en = 1'b1;
        dec_en = 1'b1;
        for (int i = 0; i < 8; i++)
            tx_pair(i[0], i[1] ^ i[2]);
        pre_en = 1'b0;
        dec_en = 1'b0;
        $display("precode test done");
    endtask : t_pre
    task automatic t_pat(input pgc_mode_type m, input int n);
        logic a;
        logic b;
        logic [3:0] want;
        do_reset();
        @(posedge core_clk);
        #1 tx_mode = m;
        for (int i = 0; i < n; i++)
        begin
            a = nbit(m == PGC_MODE_LONG);
            b = nbit(m == PGC_MODE_LONG);
            want = {1'b1, m == PGC_MODE_SHORT && i % 8191 == 0, gt[{a, b} * 2 +: 2]};
            @(posedge core_clk);
            #1 chk({tx_lv, wrap, tx_level}, want);
        end
        tx_mode = PGC_MODE_DATA;
        $display("pattern test done");
    endtask : t_pat
    initial
    begin
        t_data();
        t_pre();
        t_pat(PGC_MODE_SHORT, 8192);
        t_pat(PGC_MODE_LONG, 100);
        close_out();
    end
    initial
    begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule : tb_top
